/* File: hdl/mem2w_mst.sv */
// bus master end: runs one command per request, bit-level sequencing
module mem2w_mst (
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic        CE,
  input  wire logic        REQ,       // one-cycle command request
  input  wire logic        RD,        // 1 read, 0 write
  input  wire logic        CUR,       // read without address phase
  input  wire logic [10:0] ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic [7:0]  NBYTES,    // bytes to move, at least one
  output logic             BUSY,
  output logic             DVALID,    // read byte strobe
  output logic [7:0]       RDATA,
  output logic             WREADY,    // pulse: WDATA consumed
  output logic             NACK_ERR,
  mem2w_if.mst             BUS
);
  typedef enum logic [2:0] {
    M_IDLE  = 3'b000,
    M_START = 3'b001,
    M_BITS  = 3'b010,
    M_STOP  = 3'b011,
    M_DONE  = 3'b100
  } mphase_t;

  typedef struct packed {
    mphase_t     phase;
    logic [7:0]  half;
    logic [1:0]  q;         // step 0-3 of start/stop, half (0 or 1) within a bit
    logic [3:0]  bitn;
    logic [7:0]  sh;
    logic [1:0]  step;      // 0 word,1 addr,2 data,3 word again
    logic        rd;
    logic        cur;
    logic [10:0] addr;
    logic [7:0]  left;
    logic        scl_oe;
    logic        sda_oe;
    logic        busy;
    logic        dvalid;
    logic [7:0]  rdata;
    logic        wready;
    logic        nack;
  } mst_t;

  mst_t cur_ff;
  mst_t nxt_m;

  function automatic logic [7:0] word(input logic [2:0] up, input logic r);
    word = {mem2w_pkg::TYPE_CODE, up, r};
  endfunction : word

  // bit engine: data changes with scl low, start/stop with scl high
  always_comb begin
    logic tick;
    logic is_rx;
    nxt_m = cur_ff;
    nxt_m.dvalid = 1'b0;
    nxt_m.wready = 1'b0;
    tick  = (cur_ff.half == 8'(mem2w_pkg::HALF_PERIOD - 1));
    is_rx = cur_ff.rd && cur_ff.step == 2'h2;
    nxt_m.half = tick ? mem2w_pkg::HALF_CNT_RST : cur_ff.half + 8'h01;
    unique case (cur_ff.phase)
      M_IDLE: begin
        nxt_m.half = mem2w_pkg::HALF_CNT_RST;
        if (REQ) begin
          nxt_m.phase = M_START;
          nxt_m.busy  = 1'b1;
          nxt_m.nack  = 1'b0;
          nxt_m.rd    = RD;
          nxt_m.cur   = CUR & RD;
          nxt_m.addr  = ADDR;
          nxt_m.left  = NBYTES;
          nxt_m.step  = 2'h0;
          nxt_m.q     = 2'h0;
          nxt_m.sh    = word(ADDR[10:8], CUR & RD);
        end
      end
      M_START: if (tick) begin            // release sda, raise scl, then pull sda
        nxt_m.q = cur_ff.q + 2'h1;
        unique case (cur_ff.q)
          2'h0: begin
            nxt_m.sda_oe = 1'b0;
            nxt_m.scl_oe = 1'b0;
          end
          2'h1: nxt_m.sda_oe = 1'b1;
          2'h2: nxt_m.scl_oe = 1'b1;
          2'h3: begin
            nxt_m.phase  = M_BITS;
            nxt_m.bitn   = 4'h0;
            nxt_m.q      = 2'h0;
            nxt_m.sda_oe = ~cur_ff.sh[7];
          end
        endcase
      end
      M_BITS: if (tick) begin
        nxt_m.q = {1'b0, ~cur_ff.q[0]};
        if (cur_ff.q[0] == 1'b0) begin
          nxt_m.scl_oe = 1'b0;              // rising edge
          if (cur_ff.bitn == mem2w_pkg::ACK_BIT && !is_rx && BUS.sda) nxt_m.nack = 1'b1;
          if (cur_ff.bitn != mem2w_pkg::ACK_BIT && is_rx)
            nxt_m.sh = {cur_ff.sh[6:0], BUS.sda};
        end else begin
          nxt_m.scl_oe = 1'b1;              // falling edge
          nxt_m.bitn = cur_ff.bitn + 4'h1;
          if (cur_ff.bitn == 4'h7) begin
            // ninth bit: receiver acks, else release (never drive high)
            nxt_m.sda_oe = is_rx && cur_ff.left != 8'h01;   // last read gets nack
            if (is_rx) begin
              nxt_m.dvalid = 1'b1;
              nxt_m.rdata  = cur_ff.sh;
            end
          end else if (cur_ff.bitn == mem2w_pkg::ACK_BIT) begin
            nxt_m.bitn = 4'h0;
            if (cur_ff.nack) begin
              nxt_m.phase = M_STOP;         // caller may retry the command
            end else if (cur_ff.step == 2'h0 && !cur_ff.cur) begin
              nxt_m.step = 2'h1;
              nxt_m.sh   = cur_ff.addr[7:0];
            end else if (cur_ff.step == 2'h1 && cur_ff.rd) begin
              nxt_m.step = 2'h3;            // repeated start, same upper bits
              nxt_m.sh   = word(cur_ff.addr[10:8], 1'b1);
              nxt_m.phase = M_START;
              nxt_m.q     = 2'h0;
            end else if (cur_ff.step != 2'h2) begin
              nxt_m.step = 2'h2;
              nxt_m.sh   = cur_ff.rd ? 8'h00 : WDATA;
              nxt_m.wready = ~cur_ff.rd;
            end else if (cur_ff.left == 8'h01) begin
              nxt_m.phase = M_STOP;
            end else begin
              nxt_m.left = cur_ff.left - 8'h01;
              nxt_m.sh   = WDATA;           // further bytes: page write
              nxt_m.wready = ~cur_ff.rd;
            end
            nxt_m.sda_oe = (nxt_m.phase == M_BITS) && !(cur_ff.rd && nxt_m.step == 2'h2) && !nxt_m.sh[7];
            if (nxt_m.phase != M_BITS) nxt_m.sda_oe = 1'b0;
            if (nxt_m.phase == M_STOP) nxt_m.sda_oe = 1'b1;
          end else begin
            nxt_m.sda_oe = ~is_rx & ~cur_ff.sh[6];
            if (!is_rx) nxt_m.sh = {cur_ff.sh[6:0], 1'b0};
          end
        end
      end
      M_STOP: if (tick) begin             // sda low, scl high, release sda
        nxt_m.q = cur_ff.q + 2'h1;
        unique case (cur_ff.q)
          2'h0: nxt_m.sda_oe = 1'b1;
          2'h1: nxt_m.scl_oe = 1'b0;
          2'h2: nxt_m.sda_oe = 1'b0;
          2'h3: nxt_m.phase  = M_DONE;
        endcase
      end
      M_DONE: begin
        nxt_m.phase = M_IDLE;
        nxt_m.busy  = 1'b0;
      end
      default: nxt_m.phase = M_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cur_ff <= '{phase: M_IDLE, half: mem2w_pkg::HALF_CNT_RST, q: 2'h0, bitn: 4'h0,
                  sh: mem2w_pkg::BYTE_RST, step: 2'h0, rd: 1'b0, cur: 1'b0,
                  addr: mem2w_pkg::ADDR_RST, left: 8'h00, scl_oe: 1'b0, sda_oe: 1'b0,
                  busy: 1'b0, dvalid: 1'b0, rdata: mem2w_pkg::BYTE_RST, wready: 1'b0,
                  nack: 1'b0};
    end else if (CE) begin
      cur_ff <= nxt_m;
    end
  end

  assign BUS.scl_o      = ~cur_ff.scl_oe;
  assign BUS.scl_oe     = cur_ff.scl_oe;
  assign BUS.sda_mst_oe = cur_ff.sda_oe;
  assign BUSY           = cur_ff.busy;
  assign DVALID         = cur_ff.dvalid;
  assign RDATA          = cur_ff.rdata;
  assign WREADY         = cur_ff.wready;
  assign NACK_ERR       = cur_ff.nack;
endmodule : mem2w_mst

/* File: hdl/mem2w_pkg.sv */
// shared constants for the two-wire memory link
package mem2w_pkg;
  localparam int          ADDR_W       = 11;
  localparam int          DEPTH        = 2048;
  localparam logic [3:0]  TYPE_CODE    = 4'h5;   // arbitrary device type value
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam logic [3:0]  ACK_BIT      = 4'h8;
  localparam logic [10:0] ADDR_RST     = 11'h000;
  localparam logic [7:0]  BYTE_RST     = 8'h00;
  localparam int          HALF_PERIOD  = 4;      // master clock cycles per scl half period
  localparam logic [7:0]  HALF_CNT_RST = 8'h00;
endpackage : mem2w_pkg

/* File: hdl/mem2w_if.sv */
// two-wire bus wires with open-drain resolution and one modport per end
interface mem2w_if;
  logic scl_o;
  logic scl_oe;
  logic sda_dev_oe;
  logic sda_mst_oe;
  logic scl;
  logic sda;
  // open drain: a driver only pulls low, otherwise the pull-up wins
  assign scl = ~scl_oe;
  assign sda = ~(sda_dev_oe | sda_mst_oe);
  modport dev (input scl, input sda, output sda_dev_oe);
  modport mst (input scl, input sda, output scl_o, output scl_oe, output sda_mst_oe);
endinterface : mem2w_if

/* File: hdl/mem2w_dev.sv */
// memory slave end: command decode, address buffer and storage array
module mem2w_dev (
  input  wire logic CLK,
  input  wire logic ARST_N,
  input  wire logic CE,
  input  wire logic WP,       // tie low when unused
  mem2w_if.dev      BUS
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WORD  = 3'b001,
    ST_ADDR  = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_MACK  = 3'b101
  } phase_t;

  typedef struct packed {
    phase_t      phase;
    logic [3:0]  bitn;
    logic [7:0]  shreg;
    logic [10:0] addr;
    logic        ack;     // in the ninth bit slot
    logic        rd;
    logic        sda_oe;
    logic        scl_d;
    logic        sda_d;
    logic        wp_l;
    logic        fresh;   // address just loaded, next access uses it as is
  } state_t;

  state_t cur_ff;
  state_t nxt_st;
  logic [7:0]  mem [0:mem2w_pkg::DEPTH-1];  // contents undefined at power-up
  logic        wr_en;
  logic [10:0] wr_addr;
  logic [7:0]  wr_data;

  function automatic logic [10:0] next_addr(input logic [10:0] a);
    next_addr = a + 11'h001;                // natural wrap to zero
  endfunction : next_addr

  // next-state logic: edge detect on the sampled bus lines
  always_comb begin
    logic rise;
    logic fall;
    logic start_c;
    logic stop_c;
    logic [7:0] sh;
    nxt_st  = cur_ff;
    wr_en   = 1'b0;
    wr_addr = cur_ff.addr;
    wr_data = cur_ff.shreg;
    rise    = BUS.scl & ~cur_ff.scl_d;
    fall    = ~BUS.scl & cur_ff.scl_d;
    start_c = BUS.scl & cur_ff.scl_d & cur_ff.sda_d & ~BUS.sda;
    stop_c  = BUS.scl & cur_ff.scl_d & ~cur_ff.sda_d & BUS.sda;
    sh      = {cur_ff.shreg[6:0], BUS.sda};
    nxt_st.scl_d = BUS.scl;
    nxt_st.sda_d = BUS.sda;
    if (start_c) begin
      nxt_st.phase  = ST_WORD;
      nxt_st.bitn   = 4'h0;
      nxt_st.ack    = 1'b0;
      nxt_st.sda_oe = 1'b0;
      nxt_st.wp_l   = WP;                    // level is steady per transaction
    end else if (stop_c) begin
      nxt_st.phase  = ST_IDLE;               // abandon even mid-byte
      nxt_st.sda_oe = 1'b0;                  // address already held in buffer
      nxt_st.fresh  = 1'b0;                  // an address-only write leaves the buffer there
    end else if (cur_ff.phase != ST_IDLE) begin
      if (rise) begin                        // sample on rising edge
        if (!cur_ff.ack) begin
          if (cur_ff.phase != ST_RDATA) nxt_st.shreg = sh;
          nxt_st.bitn = cur_ff.bitn + 4'h1;
        end else if (cur_ff.phase == ST_MACK && BUS.sda) begin
          nxt_st.phase = ST_IDLE;            // master not-acknowledge ends read
        end
      end
      if (fall) begin                        // drive on falling edge
        if (!cur_ff.ack && cur_ff.bitn == mem2w_pkg::ACK_BIT) begin
          nxt_st.ack = 1'b1;
          unique case (cur_ff.phase)
            ST_WORD: begin
              if (cur_ff.shreg[7:4] != mem2w_pkg::TYPE_CODE) begin
                nxt_st.phase = ST_IDLE;      // not ours
                nxt_st.ack   = 1'b0;
              end else begin
                nxt_st.sda_oe = 1'b1;
                nxt_st.rd     = cur_ff.shreg[0];
                nxt_st.addr   = {cur_ff.shreg[3:1], cur_ff.addr[7:0]};
              end
            end
            ST_ADDR: begin
              nxt_st.sda_oe = 1'b1;
              nxt_st.addr   = {cur_ff.addr[10:8], cur_ff.shreg};
              nxt_st.fresh  = 1'b1;          // first access goes to this address
            end
            ST_WDATA: begin
              nxt_st.sda_oe = 1'b1;          // acked even when protected
              wr_en   = ~cur_ff.wp_l;
              wr_addr = cur_ff.fresh ? cur_ff.addr : next_addr(cur_ff.addr);
              wr_data = cur_ff.shreg;
              nxt_st.addr  = wr_addr;        // buffer follows each byte, protected or not
              nxt_st.fresh = 1'b0;
            end
            ST_RDATA: begin
              nxt_st.sda_oe = 1'b0;          // release for master acknowledge
              nxt_st.phase  = ST_MACK;
            end
            ST_MACK: nxt_st.sda_oe = 1'b0;
          endcase
        end else if (cur_ff.ack) begin
          nxt_st.ack    = 1'b0;
          nxt_st.bitn   = 4'h0;
          nxt_st.sda_oe = 1'b0;
          unique case (cur_ff.phase)
            ST_WORD: begin
              if (cur_ff.rd) begin           // reads ignore write-protect
                nxt_st.phase  = ST_RDATA;
                // random read starts at the loaded address, current read at n+1
                nxt_st.addr   = cur_ff.fresh ? cur_ff.addr : next_addr(cur_ff.addr);
                nxt_st.fresh  = 1'b0;
              end else begin
                nxt_st.phase  = ST_ADDR;
              end
            end
            ST_ADDR:  nxt_st.phase = ST_WDATA;
            ST_WDATA: nxt_st.phase = ST_WDATA;  // address moves when the byte is stored
            ST_MACK: begin                   // master acknowledged: next byte
              nxt_st.phase = ST_RDATA;
              nxt_st.addr  = next_addr(cur_ff.addr);
            end
            default: nxt_st.phase = ST_IDLE;
          endcase
          if (nxt_st.phase == ST_RDATA) begin
            nxt_st.shreg  = mem[nxt_st.addr];
            nxt_st.sda_oe = ~mem[nxt_st.addr][7];
          end
        end else if (cur_ff.phase == ST_RDATA) begin
          nxt_st.sda_oe = ~cur_ff.shreg[mem2w_pkg::BIT_LAST - cur_ff.bitn[2:0]];
        end
      end
    end
  end

  // state register; address after read/write reflects last byte
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cur_ff <= '{phase: ST_IDLE, bitn: 4'h0, shreg: mem2w_pkg::BYTE_RST,
                  addr: mem2w_pkg::ADDR_RST, ack: 1'b0, rd: 1'b0, sda_oe: 1'b0,
                  scl_d: 1'b1, sda_d: 1'b1, wp_l: 1'b0, fresh: 1'b0};
    end else if (CE) begin
      cur_ff <= nxt_st;
    end
  end

  // storage array write port
  always_ff @(posedge CLK) begin
    if (CE && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign BUS.sda_dev_oe = cur_ff.sda_oe;
endmodule : mem2w_dev

/* File: tb/mem2w_monitor.sv */
// wire-level checker for the two-wire memory link
module mem2w_monitor (
  input  wire logic CLK,
  input  wire logic ARST_N,
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic sda_dev_oe,
  input  wire logic sda_mst_oe
);
  logic       scl_ff;
  logic       sda_ff;
  logic [3:0] bit_ff;
  logic [1:0] byte_ff;
  logic [7:0] shift_ff;
  logic       wr_ff;
  logic       nak_ff;   // last ninth bit was high: next rise sets up stop
  logic       rise;
  logic       stop;
  logic       start;
  // bus events seen on the resolved wires
  assign rise  = scl & ~scl_ff;
  assign start = scl & scl_ff & sda_ff & ~sda;
  assign stop  = scl & scl_ff & ~sda_ff & sda;
  // bit slot, byte index and direction of the running frame
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      scl_ff   <= 1'b1;
      sda_ff   <= 1'b1;
      bit_ff   <= 4'h0;
      byte_ff  <= 2'h0;
      shift_ff <= 8'h00;
      wr_ff    <= 1'b0;
      nak_ff   <= 1'b0;
    end else begin
      scl_ff <= scl;
      sda_ff <= sda;
      if (start) begin
        bit_ff  <= 4'h0;
        byte_ff <= 2'h0;
        wr_ff   <= 1'b0;
        nak_ff  <= 1'b0;
      end else if (rise && bit_ff == 4'h8) begin
        bit_ff  <= 4'h0;
        nak_ff  <= sda;
        byte_ff <= (byte_ff == 2'h3) ? byte_ff : byte_ff + 2'h1;  // saturates: only first byte matters
        wr_ff   <= (byte_ff == 2'h0) ? ~shift_ff[0] : wr_ff;
      end else if (rise) begin
        bit_ff   <= bit_ff + 4'h1;
        shift_ff <= {shift_ff[6:0], sda};
      end
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  a_dev_edge: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("device moved sda while scl high");
  a_no_fight: assert property (scl |-> !(sda_dev_oe && sda_mst_oe))
    else $error("both ends pull sda in one bit");
  a_word_acked: assert property (rise && bit_ff == 4'h8 && byte_ff == 2'h0
    && shift_ff[7:4] == mem2w_pkg::TYPE_CODE |-> sda_dev_oe) else $error("matching word not acked");
  a_write_acked: assert property (rise && bit_ff == 4'h8 && byte_ff != 2'h0 && wr_ff |-> sda_dev_oe)
    else $error("write byte not acked");
  a_dev_listens: assert property (rise && bit_ff != 4'h8 && (byte_ff == 2'h0 || wr_ff) |-> !sda_dev_oe)
    else $error("device drove a received bit");
  a_read_ack_free: assert property (rise && bit_ff == 4'h8 && byte_ff != 2'h0 && !wr_ff |-> !sda_dev_oe)
    else $error("device held sda in master ack slot");
  a_master_listens: assert property (rise && bit_ff != 4'h8 && byte_ff != 2'h0 && !wr_ff && !nak_ff
    |-> !sda_mst_oe) else $error("master drove a read data bit");
  a_nack_stops: assert property (rise && nak_ff |-> sda_mst_oe)
    else $error("master did not set up stop after a not-acknowledge");
  a_idle_after_stop: assert property (stop |-> !sda_dev_oe [*5])
    else $error("device active after stop");
endmodule : mem2w_monitor

/* File: tb/test_i2c_memory_command_slave.sv */
// self-checking bench: master and memory ends joined over the two-wire link
module test_i2c_memory_command_slave;
  timeunit 1ns;
  timeprecision 100ps;
  logic        CLK;
  logic        ARST_N;
  logic        WP;
  logic        REQ;
  logic        RD;
  logic        CUR;
  logic [10:0] ADDR;
  logic [7:0]  WDATA;
  logic [7:0]  NBYTES;
  logic        BUSY;
  logic        DVALID;
  logic [7:0]  RDATA;
  logic        WREADY;
  logic        NACK_ERR;
  int          error_cnt;
  int          comparisons;
  logic [7:0]  mem [2048];
  logic [7:0]  wq [$];
  logic [7:0]  exq [$];
  logic [7:0]  d;
  logic [10:0] a;
  mem2w_if bus ();
  mem2w_dev i_mem2w_dev (.CLK(CLK), .ARST_N(ARST_N), .CE(1'b1), .WP(WP), .BUS(bus));
  mem2w_mst i_mem2w_mst (.CLK(CLK), .ARST_N(ARST_N), .CE(1'b1), .REQ(REQ), .RD(RD), .CUR(CUR), .ADDR(ADDR),
    .WDATA(WDATA), .NBYTES(NBYTES), .BUSY(BUSY), .DVALID(DVALID), .RDATA(RDATA), .WREADY(WREADY),
    .NACK_ERR(NACK_ERR), .BUS(bus));
  mem2w_monitor i_mem2w_monitor (.CLK(CLK), .ARST_N(ARST_N), .scl(bus.scl), .sda(bus.sda),
    .sda_dev_oe(bus.sda_dev_oe), .sda_mst_oe(bus.sda_mst_oe));
  // 40 MHz clock
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  task automatic test_done();
    if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one command: request pulse, feed write bytes on WREADY, wait for idle
  task automatic cmd(input logic rd, input logic cur, input logic [10:0] ad, input int n);
    int t;
    @(posedge CLK) #1;
    RD = rd;
    CUR = cur;
    ADDR = ad;
    NBYTES = 8'(n);
    REQ = 1'b1;
    if (wq.size() > 0) WDATA = wq.pop_front();
    @(posedge CLK) #1;
    REQ = 1'b0;
    t = 0;
    while (BUSY !== 1'b0 && t < 20000) begin
      if (WREADY === 1'b1 && wq.size() > 0) WDATA = wq.pop_front();
      @(posedge CLK) #1;
      t++;
    end
    chk("busy", {7'h00, BUSY}, 8'h00);
    chk("nack_err", {7'h00, NACK_ERR}, 8'h00);
  endtask : cmd
  // write n random bytes; the model changes only when unprotected
  task automatic wr(input logic [10:0] ad, input int n, input logic wp);
    WP = wp;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      wq.push_back(d);
      if (!wp) mem[11'(ad + 11'(i))] = d;
    end
    cmd(1'b0, 1'b0, ad, n);
  endtask : wr
  // read n bytes, expected from model address e upward, random protect level
  task automatic rd(input logic [10:0] ad, input int n, input logic cur, input logic [10:0] e);
    WP = 1'($urandom);
    for (int i = 0; i < n; i++) exq.push_back(mem[11'(e + 11'(i))]);
    cmd(1'b1, cur, ad, n);
  endtask : rd
  // read byte watcher: each strobe takes the oldest expectation
  always begin
    @(posedge CLK);
    #2;
    if (DVALID === 1'b1) chk("rdata", RDATA, (exq.size() > 0) ? exq.pop_front() : 8'hxx);
  end
  initial begin
    repeat (60000) @(posedge CLK);
    error_cnt++;
    test_done();
  end
  initial begin
    error_cnt = 0;
    comparisons = 0;
    ARST_N = 1'b0;
    WP = 1'b0;
    REQ = 1'b0;
    RD = 1'b0;
    CUR = 1'b0;
    ADDR = 11'h000;
    WDATA = 8'h00;
    NBYTES = 8'h01;
    void'($urandom(51932));
    repeat (3) @(posedge CLK);
    #1 ARST_N = 1'b1;
    // write across the top of the array, then a blocked overwrite
    wr(11'h7fe, 4, 1'b0);
    wr(11'h7fe, 2, 1'b1);
    // buffer follows a blocked write too: current read after 7ff wraps
    rd(11'h700, 1, 1'b1, 11'h000);
    rd(11'h7fe, 4, 1'b0, 11'h7fe);
    // buffer left at the last location: current read wraps, then steps
    rd(11'h7fe, 2, 1'b0, 11'h7fe);
    rd(11'h700, 1, 1'b1, 11'h000);
    rd(11'h000, 1, 1'b1, 11'h001);
    // random places: write three, read two back, then current read
    for (int k = 0; k < 4; k++) begin
      a = 11'($urandom) & 11'h7f7;
      wr(a, 3, 1'b0);
      rd(a, 2, 1'b0, a);
      rd({a[10:8], 8'h00}, 1, 1'b1, {a[10:8], 8'(a[7:0] + 8'h01)} + 11'h001);
    end
    repeat (4) @(posedge CLK);
    chk("pending", 8'(exq.size()), 8'h00);
    test_done();
  end
endmodule : test_i2c_memory_command_slave
